/* phyan_pkg.sv */
package phyan_pkg;

  // Management register indices (clause 22 direct space)
  localparam logic [4:0] REG_BMC    = 5'h00;
  localparam logic [4:0] REG_BMS    = 5'h01;
  localparam logic [4:0] REG_ADV    = 5'h04;
  localparam logic [4:0] REG_LPA    = 5'h05;
  localparam logic [4:0] REG_EXP    = 5'h06;
  localparam logic [4:0] REG_NPT    = 5'h07;
  localparam logic [4:0] REG_EAC    = 5'h0d;
  localparam logic [4:0] REG_EAD    = 5'h0e;
  localparam logic [4:0] REG_PSC    = 5'h10;
  localparam logic [15:0] EXT_CLKOUT = 16'h0170;
  localparam logic [15:0] STD_LIMIT  = 16'h0020;

  // Reset values
  localparam logic [15:0] BMC_RST    = 16'h1140;
  localparam logic [15:0] ADV_RST    = 16'h01e1;
  localparam logic [15:0] NPT_RST    = 16'h2001;
  localparam logic [15:0] PSC_RST    = 16'h5048;
  localparam logic [15:0] CLKOUT_RST = 16'h0c10;
  localparam logic [15:0] BMS_CAP    = 16'h7908;

  // Field positions
  localparam int BMC_RESTART  = 9;
  localparam int BMC_AN_EN    = 12;
  localparam int BMS_AN_DONE  = 5;
  localparam int BMS_LINK     = 2;
  localparam int EXP_LP_ABLE  = 0;
  localparam int EXP_PD_FAULT = 4;
  localparam int PSC_AUTO_X   = 6;
  localparam int PSC_FORCE_X  = 5;
  localparam int CLKOUT_DIS   = 6;
  localparam int PG_NEXT      = 15;

  // Indirect access control
  localparam logic [4:0] TARGET_DEVICE_ADDRESS_GEN = 5'h1f;
  localparam logic [1:0] FN_ADDR   = 2'h0;
  localparam logic [1:0] FN_DATA   = 2'h1;
  localparam logic [1:0] FN_INC_RW = 2'h2;
  localparam logic [1:0] FN_INC_W  = 2'h3;
  localparam logic [4:0] PD_SELECTOR = 5'h01;

  // Timing
  localparam int CLK_KHZ     = 100000;
  localparam int BRK_TIME_MS = 1200;
  localparam int STRAP_WAIT  = 2;
  localparam int DATA_BITS   = 16;

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} phyan_speed_t;

  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [4:0]  ra;
    logic [15:0] data;
  } phyan_acc_t;

  typedef struct packed {
    logic       std;
    logic       ext;
    logic [4:0] idx;
  } phyan_tgt_t;

endpackage

/* phyan_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - Control 0x1F selects address function; address/data writes then set extended address.
// - Function 01: repeated accesses hit same register, extended address unchanged.
// - Function 10: extended address advances after every read and write.
// - Function 11: extended address advances after every write.
// - Clock output config at 170h resets 0xC10; writing 0x0C50 stops clock output.
// - Advertisement bits 10 and 11 advertise symmetric and asymmetric pause.
// - Partner ability bits 10 and 11 report partner pause abilities.
// - No pause resolution here; MAC reads partner ability to choose pause.
// - Next page exchange supported, content from next page transmit register.
// - Parallel detect completion sets partner bits 5/7 and selector 00001.
// - Expansion bit 0 reads 0 after completion by parallel detection.
// - Parallel detect fault flag, expansion bit 4, sets on bad link condition.
// - Lost negotiated link resumes negotiation automatically.
// - Writing control bit 9 restarts negotiation any time while negotiation is enabled (control bit 12 set).
// - Restart halts transmission until break link timer ends, then sends bursts.
// - Strap-disabled negotiation cannot be re-enabled by register writes.
// - Control 10h bit 6 enables auto crossover; else pairs forced.
// - Control 10h bit 5 selects manual straight or crossed pairs.
// - Crossover resolves before exchange and independent of negotiation at 10/100.
// - Choose highest common mode; gigabit also resolves master or slave.
// - Indirect accesses with device address other than 11111 are ignored.
// - Function 11: read leaves extended address unchanged.
// - Access control and address/data registers unreachable indirectly.
module phyan_regs
  import phyan_pkg::*;
#(
  parameter int EXT_AW  = 5,
  parameter int BRK_CYC = BRK_TIME_MS * CLK_KHZ
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  strap_phy_addr,
  input  wire logic        strap_an_dis,
  input  wire logic        strap_auto_x_dis,
  input  wire logic        strap_force_x,
  input  wire logic        link_ok,
  input  wire logic        lp_page_vld,
  input  wire logic        lp_np_vld,
  input  wire logic [15:0] lp_page,
  input  wire logic        pd_detect,
  input  wire logic        pd_100,
  input  wire logic        pd_fault,
  input  wire logic        x_detect,
  input  wire logic        gig_local,
  input  wire logic        gig_partner,
  input  wire logic        multiport_local,
  input  wire logic        multiport_partner,
  output logic             clk_out_en,
  output logic             tx_halt,
  output logic             flp_en,
  output logic             an_complete,
  output logic [1:0]       speed_sel,
  output logic             full_duplex,
  output logic             gig_master,
  output logic             crossed_sel,
  output logic [15:0]      tx_base_page,
  output logic [15:0]      np_tx_word
);

  initial begin
    if (EXT_AW < 1 || EXT_AW > 12) $error("EXT_AW out of range");
    if (BRK_CYC < 2) $error("BRK_CYC too small");
  end

  typedef enum logic [2:0] {
    MF_IDLE, MF_START, MF_OP, MF_PHY, MF_REG, MF_TA, MF_DATA
  } phyan_mf_t;
  typedef enum logic [2:0] {
    AN_OFF, AN_BREAK, AN_XCHG, AN_NEXT, AN_GOOD
  } phyan_an_t;

  logic [2:0]  mdc_sync_ff;
  logic [1:0]  mdio_sync_ff;
  logic        mdc_rise;
  logic        mdio_bit;
  phyan_mf_t   mf_ff;
  logic [4:0]  bitcnt_ff;
  logic [1:0]  op_ff;
  logic [4:0]  phy_ff;
  logic [4:0]  ra_ff;
  logic [15:0] shift_ff;
  logic        mine_rd_ff;
  phyan_acc_t  acc_ff;
  logic [1:0]  strap_sync_ff [4];
  logic [4:0]  addr_s1_ff, addr_s2_ff, my_addr_ff;
  logic [1:0]  strap_cnt_ff;
  logic        strap_an_dis_ff;
  logic [15:0] bmc_ff, adv_ff, lpa_ff, exp_ff, npt_ff, eac_ff, psc_ff;
  logic [15:0] ext_addr_ff, clkout_ff;
  logic [15:0] ext_mem [2**EXT_AW];
  phyan_an_t   an_ff;
  logic [31:0] brk_ff;
  logic        link_d_ff;
  logic        restart_req;
  phyan_tgt_t  acc_t;
  logic        acc_ead, acc_dev_ok, acc_inc;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strap capture after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_sync_ff  <= 3'h0;
      mdio_sync_ff <= 2'h3;
    end else begin
      mdc_sync_ff  <= {mdc_sync_ff[1:0], mdc};
      mdio_sync_ff <= {mdio_sync_ff[0], mdio_in};
    end
  end
  assign mdc_rise = mdc_sync_ff[1] & ~mdc_sync_ff[2];
  assign mdio_bit = mdio_sync_ff[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) strap_sync_ff[i] <= 2'h0;
      addr_s1_ff   <= 5'h00;
      addr_s2_ff   <= 5'h00;
      my_addr_ff   <= 5'h00;
      strap_cnt_ff <= 2'h0;
    end else begin
      strap_sync_ff[0] <= {strap_sync_ff[0][0], strap_an_dis};
      strap_sync_ff[1] <= {strap_sync_ff[1][0], strap_auto_x_dis};
      strap_sync_ff[2] <= {strap_sync_ff[2][0], strap_force_x};
      strap_sync_ff[3] <= 2'h0;
      addr_s1_ff <= strap_phy_addr;
      addr_s2_ff <= addr_s1_ff;
      // Capture once both sync stages hold the strap level
      if (strap_cnt_ff != 2'(STRAP_WAIT + 1))
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'(STRAP_WAIT)) my_addr_ff <= addr_s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect target resolution
  function automatic phyan_tgt_t resolve(input logic [4:0] ra);
    phyan_tgt_t t;
    t = '{std: 1'b1, ext: 1'b0, idx: ra};
    if (ra == REG_EAD) begin
      t.std = 1'b0;
      if (eac_ff[4:0] == TARGET_DEVICE_ADDRESS_GEN && eac_ff[15:14] != FN_ADDR) begin
        if (ext_addr_ff >= STD_LIMIT) begin
          t.ext = 1'b1;
        end else if (ext_addr_ff[4:0] != REG_EAC && ext_addr_ff[4:0] != REG_EAD)
        begin
          t.std = 1'b1;
          t.idx = ext_addr_ff[4:0];
        end
      end
    end
    return t;
  endfunction

  function automatic logic [15:0] std_rd(input logic [4:0] a);
    logic [15:0] bms;
    bms = BMS_CAP;
    bms[BMS_AN_DONE] = (an_ff == AN_GOOD);
    bms[BMS_LINK] = link_d_ff;
    unique case (a)
      REG_BMC: std_rd = bmc_ff;
      REG_BMS: std_rd = bms;
      REG_ADV: std_rd = adv_ff;
      REG_LPA: std_rd = lpa_ff;
      REG_EXP: std_rd = exp_ff;
      REG_NPT: std_rd = npt_ff;
      REG_EAC: std_rd = eac_ff;
      REG_PSC: std_rd = psc_ff;
      default: std_rd = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] frame_rd(input logic [4:0] ra);
    phyan_tgt_t t;
    t = resolve(ra);
    if (ra == REG_EAD && eac_ff[4:0] == TARGET_DEVICE_ADDRESS_GEN && eac_ff[15:14] == FN_ADDR)
      frame_rd = ext_addr_ff;
    else if (t.ext)
      frame_rd = (ext_addr_ff == EXT_CLKOUT) ? clkout_ff
               : ext_mem[ext_addr_ff[EXT_AW-1:0]];
    else if (t.std)
      frame_rd = std_rd(t.idx);
    else
      frame_rd = 16'h0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Management frame receiver and turnaround driver
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mf_ff      <= MF_IDLE;
      bitcnt_ff  <= 5'h00;
      op_ff      <= 2'h0;
      phy_ff     <= 5'h00;
      ra_ff      <= 5'h00;
      shift_ff   <= 16'h0000;
      mine_rd_ff <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
      acc_ff     <= '0;
    end else begin
      acc_ff.vld <= 1'b0;
      if (mdc_rise) begin
        bitcnt_ff <= bitcnt_ff + 5'h01;
        unique case (mf_ff)
          MF_IDLE: begin
            if (!mdio_bit) mf_ff <= MF_START;
          end
          MF_START: begin
            mf_ff     <= mdio_bit ? MF_OP : MF_IDLE;
            bitcnt_ff <= 5'h00;
          end
          MF_OP: begin
            op_ff <= {op_ff[0], mdio_bit};
            if (bitcnt_ff == 5'h01) begin
              mf_ff     <= MF_PHY;
              bitcnt_ff <= 5'h00;
            end
          end
          MF_PHY: begin
            phy_ff <= {phy_ff[3:0], mdio_bit};
            if (bitcnt_ff == 5'h04) begin
              mf_ff     <= MF_REG;
              bitcnt_ff <= 5'h00;
            end
          end
          MF_REG: begin
            ra_ff <= {ra_ff[3:0], mdio_bit};
            if (bitcnt_ff == 5'h04) begin
              mf_ff      <= MF_TA;
              bitcnt_ff  <= 5'h00;
              mine_rd_ff <= (phy_ff == my_addr_ff) && (op_ff == 2'h2);
              shift_ff   <= frame_rd({ra_ff[3:0], mdio_bit});
            end
          end
          MF_TA: begin
            // First turnaround bit left undriven to avoid contention
            if (bitcnt_ff == 5'h00) begin
              mdio_oe  <= mine_rd_ff;
              mdio_out <= 1'b0;
            end else begin
              mf_ff     <= MF_DATA;
              bitcnt_ff <= 5'h00;
              mdio_out  <= shift_ff[15];
              shift_ff  <= {shift_ff[14:0], mdio_bit};
            end
          end
          MF_DATA: begin
            mdio_out <= shift_ff[15];
            shift_ff <= {shift_ff[14:0], mdio_bit};
            if (bitcnt_ff == 5'(DATA_BITS - 1)) begin
              mf_ff      <= MF_IDLE;
              mdio_oe    <= 1'b0;
              mine_rd_ff <= 1'b0;
              acc_ff.vld <= (phy_ff == my_addr_ff) &&
                            (op_ff == 2'h1 || op_ff == 2'h2);
              acc_ff.wr  <= (op_ff == 2'h1);
              acc_ff.ra  <= ra_ff;
              acc_ff.data <= {shift_ff[14:0], mdio_bit};
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and indirect access
  // Resolver reads register state, so it must not be a plain assign
  always_comb acc_t = resolve(acc_ff.ra);
  assign acc_ead    = acc_ff.vld && acc_ff.ra == REG_EAD;
  assign acc_dev_ok = eac_ff[4:0] == TARGET_DEVICE_ADDRESS_GEN;
  assign acc_inc    = acc_ead && acc_dev_ok &&
                      (eac_ff[15:14] == FN_INC_RW ||
                       (eac_ff[15:14] == FN_INC_W && acc_ff.wr));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eac_ff      <= 16'h0000;
      ext_addr_ff <= 16'h0000;
      clkout_ff   <= CLKOUT_RST;
    end else begin
      if (acc_ff.vld && acc_ff.wr && acc_ff.ra == REG_EAC) eac_ff <= acc_ff.data;
      if (acc_ead && acc_dev_ok && acc_ff.wr && eac_ff[15:14] == FN_ADDR)
        ext_addr_ff <= acc_ff.data;
      else if (acc_inc)
        ext_addr_ff <= ext_addr_ff + 16'h0001;
      if (acc_ff.vld && acc_ff.wr && acc_t.ext && ext_addr_ff == EXT_CLKOUT)
        clkout_ff <= acc_ff.data;
    end
  end

  // Extended words alias on the low address bits; only 170h is distinct
  always_ff @(posedge mclk) begin
    if (acc_ff.vld && acc_ff.wr && acc_t.ext && ext_addr_ff != EXT_CLKOUT)
      ext_mem[ext_addr_ff[EXT_AW-1:0]] <= acc_ff.data;
  end

  assign restart_req = acc_ff.vld && acc_ff.wr && acc_t.std &&
                       acc_t.idx == REG_BMC &&
                       (acc_ff.data[BMC_RESTART] ||
                        (acc_ff.data[BMC_AN_EN] && !bmc_ff[BMC_AN_EN]));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bmc_ff <= BMC_RST;
      adv_ff <= ADV_RST;
      npt_ff <= NPT_RST;
      psc_ff <= PSC_RST;
      strap_an_dis_ff <= 1'b0;
    end else if (strap_cnt_ff == 2'(STRAP_WAIT)) begin
      strap_an_dis_ff <= strap_sync_ff[0][1];
      bmc_ff[BMC_AN_EN] <= ~strap_sync_ff[0][1];
      psc_ff[PSC_AUTO_X] <= ~strap_sync_ff[1][1];
      psc_ff[PSC_FORCE_X] <= strap_sync_ff[2][1];
    end else if (acc_ff.vld && acc_ff.wr && acc_t.std) begin
      unique case (acc_t.idx)
        REG_BMC: begin
          bmc_ff <= acc_ff.data & ~(16'h0001 << BMC_RESTART);
          if (strap_an_dis_ff) bmc_ff[BMC_AN_EN] <= 1'b0;
        end
        REG_ADV: adv_ff <= acc_ff.data;
        REG_NPT: npt_ff <= acc_ff.data;
        REG_PSC: psc_ff <= acc_ff.data;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      an_ff     <= AN_OFF;
      brk_ff    <= 32'h0;
      link_d_ff <= 1'b0;
      lpa_ff    <= 16'h0000;
      exp_ff    <= 16'h0000;
    end else begin
      link_d_ff <= link_ok;
      // Fault flag clears on read, but a new fault in that cycle wins
      if (acc_ff.vld && !acc_ff.wr && acc_t.std && acc_t.idx == REG_EXP)
        exp_ff[EXP_PD_FAULT] <= 1'b0;
      if (pd_fault && an_ff == AN_XCHG)
        exp_ff[EXP_PD_FAULT] <= 1'b1;
      if (!bmc_ff[BMC_AN_EN]) begin
        an_ff <= AN_OFF;
      end else if (restart_req || an_ff == AN_OFF) begin
        an_ff  <= AN_BREAK;
        brk_ff <= 32'h0;
      end else begin
        unique case (an_ff)
          AN_BREAK: begin
            brk_ff <= brk_ff + 32'h1;
            if (brk_ff == 32'(BRK_CYC - 1)) an_ff <= AN_XCHG;
          end
          AN_XCHG: begin
            if (lp_page_vld) begin
              lpa_ff <= lp_page;
              exp_ff[EXP_LP_ABLE] <= 1'b1;
              an_ff <= (lp_page[PG_NEXT] && npt_ff[PG_NEXT]) ? AN_NEXT
                     : AN_GOOD;
            end else if (pd_detect) begin
              lpa_ff <= {8'h00, pd_100, 1'b0, ~pd_100, PD_SELECTOR};
              exp_ff[EXP_LP_ABLE] <= 1'b0;
              an_ff <= AN_GOOD;
            end
          end
          AN_NEXT: begin
            if (lp_np_vld && !lp_page[PG_NEXT]) an_ff <= AN_GOOD;
          end
          AN_GOOD: begin
            if (link_d_ff && !link_ok) an_ff <= AN_XCHG;
          end
          default: an_ff <= AN_OFF;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resolution and registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_en   <= 1'b1;
      tx_halt      <= 1'b0;
      flp_en       <= 1'b0;
      an_complete  <= 1'b0;
      speed_sel    <= SPD_10;
      full_duplex  <= 1'b0;
      gig_master   <= 1'b0;
      crossed_sel  <= 1'b0;
      tx_base_page <= ADV_RST;
      np_tx_word   <= NPT_RST;
    end else begin
      clk_out_en   <= ~clkout_ff[CLKOUT_DIS];
      tx_halt      <= an_ff == AN_BREAK;
      flp_en       <= an_ff == AN_XCHG || an_ff == AN_NEXT;
      an_complete  <= an_ff == AN_GOOD;
      tx_base_page <= adv_ff;
      np_tx_word   <= npt_ff;
      // Crossover runs apart from negotiation state
      crossed_sel  <= psc_ff[PSC_AUTO_X] ? x_detect : psc_ff[PSC_FORCE_X];
      if (an_ff == AN_GOOD) begin
        if (gig_local && gig_partner) begin
          speed_sel   <= SPD_1000;
          full_duplex <= 1'b1;
          gig_master  <= multiport_local || !multiport_partner;
        end else if (adv_ff[8] && lpa_ff[8]) begin
          speed_sel   <= SPD_100;
          full_duplex <= 1'b1;
        end else if (adv_ff[7] && lpa_ff[7]) begin
          speed_sel   <= SPD_100;
          full_duplex <= 1'b0;
        end else begin
          speed_sel   <= SPD_10;
          full_duplex <= adv_ff[6] && lpa_ff[6];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_CLKOUT: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ff.vld && acc_ff.wr && acc_t.ext && ext_addr_ff == EXT_CLKOUT
    |-> ##2 clk_out_en == ~$past(acc_ff.data[CLKOUT_DIS], 2))
    else $error("clock output enable does not follow config");
  AST_NOINC: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ead && eac_ff[15:14] == FN_DATA |=> $stable(ext_addr_ff))
    else $error("address moved in no-increment mode");
  AST_INCRW: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ead && acc_dev_ok && eac_ff[15:14] == FN_INC_RW
    |=> ext_addr_ff == $past(ext_addr_ff) + 16'h0001)
    else $error("address not advanced after access");
  AST_INCW: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ead && acc_dev_ok && acc_ff.wr && eac_ff[15:14] == FN_INC_W
    |=> ext_addr_ff == $past(ext_addr_ff) + 16'h0001)
    else $error("address not advanced after write");
  AST_RDKEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ead && !acc_ff.wr && eac_ff[15:14] == FN_INC_W |=> $stable(ext_addr_ff))
    else $error("address moved on read in write-increment mode");
  AST_TARGET_DEVICE_ADDRESS: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_ead && !acc_dev_ok |=> $stable(ext_addr_ff) && $stable(clkout_ff))
    else $error("wrong device address not ignored");
  AST_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
    strap_an_dis_ff && strap_cnt_ff == 2'(STRAP_WAIT + 1)
    |-> !bmc_ff[BMC_AN_EN])
    else $error("strap-disabled negotiation re-enabled");
  AST_BREAK: assert property (@(posedge mclk) disable iff (!rst_n)
    restart_req && bmc_ff[BMC_AN_EN] |=> an_ff == AN_BREAK ##1 tx_halt)
    else $error("restart did not halt transmission");
  AST_PDSEL: assert property (@(posedge mclk) disable iff (!rst_n)
    an_ff == AN_XCHG && bmc_ff[BMC_AN_EN] && !restart_req && !lp_page_vld &&
    pd_detect |=> lpa_ff[4:0] == PD_SELECTOR && !exp_ff[EXP_LP_ABLE])
    else $error("parallel detect result wrong");
  AST_XOVER: assert property (@(posedge mclk) disable iff (!rst_n)
    !psc_ff[PSC_AUTO_X] && $stable(psc_ff)
    |=> crossed_sel == $past(psc_ff[PSC_FORCE_X]))
    else $error("forced crossover not applied");

endmodule // phyan_regs

/* phyan_sta.sv */
`timescale 1ns/1ps
module phyan_sta (
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  logic drv;
  logic oe;
  // Pull-up wins while nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (oe ? drv : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    oe  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One frame; MDC stands still between frames, station releases on read
  task automatic frame(input logic rd, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [35:0] w;
    w = {4'hf, 2'b01, rd ? 2'b10 : 2'b01, 5'h00, ra, 2'b10, wd};
    for (int i = 35; i >= 0; i--) begin
      oe  = !(rd && i < 18);
      drv = w[i];
      #80 mdc = 1'b1;
      if (i < 16) q[i] = mdio_in;
      #80 mdc = 1'b0;
    end
    oe = 1'b0;
  endtask
endmodule // phyan_sta

/* phyan_regs_bench.sv */
`timescale 1ns/1ps
module phyan_regs_bench
  import phyan_pkg::*;
;
  logic        mclk, rst_n, mdc, mdio_in, mdio_out, mdio_oe;
  logic        link_ok, lp_page_vld, lp_np_vld, pd_detect, pd_100, pd_fault;
  logic        x_detect, clk_out_en, tx_halt, flp_en, an_complete;
  logic        full_duplex, gig_master, crossed_sel;
  logic        gig_local, gig_partner, multiport_local, multiport_partner;
  logic [1:0]  speed_sel;
  logic [15:0] lp_page, tx_base_page, np_tx_word, v;
  int          miscompares, total_checks;
  phyan_regs #(.BRK_CYC(20)) i_phyan_regs (.mclk, .rst_n, .mdc, .mdio_in,
    .mdio_out, .mdio_oe, .strap_phy_addr(5'h00), .strap_an_dis(1'b0),
    .strap_auto_x_dis(1'b0), .strap_force_x(1'b0), .link_ok, .lp_page_vld,
    .lp_np_vld, .lp_page, .pd_detect, .pd_100, .pd_fault, .x_detect,
    .gig_local, .gig_partner, .multiport_local, .multiport_partner,
    .clk_out_en, .tx_halt, .flp_en, .an_complete,
    .speed_sel, .full_duplex, .gig_master, .crossed_sel, .tx_base_page,
    .np_tx_word);
  phyan_sta i_phyan_sta (.mdc, .mdio_in, .mdio_out, .mdio_oe);
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Frames start on a falling edge so MDC never moves at a sampling edge
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    @(negedge mclk);
    i_phyan_sta.frame(1'b0, ra, d, v);
  endtask
  task automatic rd(input logic [4:0] ra);
    @(negedge mclk);
    i_phyan_sta.frame(1'b1, ra, 16'h0000, v);
  endtask
  task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
    rd(ra);
    chk(v, exp);
  endtask
  task automatic seta(input logic [15:0] a);
    wr(REG_EAC, 16'h001f);
    wr(REG_EAD, a);
  endtask
  task automatic wait_flp();
    for (int i = 0; i < 200 && flp_en !== 1'b1; i++) @(posedge mclk);
  endtask
  task automatic final_report();
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(REG_BMC, BMC_RST);
    rdc(REG_PSC, PSC_RST);
    seta(EXT_CLKOUT);
    wr(REG_EAC, 16'h401f);
    rdc(REG_EAD, CLKOUT_RST);
    wr(REG_EAD, 16'h0c50);
    chk({15'h0, clk_out_en}, 16'h0000);
    wr(REG_ADV, 16'h0de1);
    chk(tx_base_page, 16'h0de1);
    wr(REG_NPT, 16'h2005);
    chk(np_tx_word, 16'h2005);
  endtask
  task automatic t_ext();
    seta(16'h0100);
    wr(REG_EAC, 16'h801f);
    wr(REG_EAD, 16'h1111);
    wr(REG_EAD, 16'h2222);
    rd(REG_EAD);
    wr(REG_EAC, 16'h001f);
    rdc(REG_EAD, 16'h0103);
    wr(REG_EAD, 16'h0100);
    wr(REG_EAC, 16'h401f);
    rdc(REG_EAD, 16'h1111);
    rdc(REG_EAD, 16'h1111);
    wr(REG_EAC, 16'hc01f);
    rdc(REG_EAD, 16'h1111);
    wr(REG_EAD, 16'h3333);
    wr(REG_EAC, 16'h001f);
    rdc(REG_EAD, 16'h0101);
    seta(16'hffff);
    wr(REG_EAC, 16'h801f);
    wr(REG_EAD, 16'h1234);
    wr(REG_EAC, 16'h001f);
    rdc(REG_EAD, 16'h0000);
    seta(16'h0100);
    wr(REG_EAC, 16'h401e);
    wr(REG_EAD, 16'hdead);
    rdc(REG_EAD, 16'h0000);
    wr(REG_EAC, 16'h401f);
    rdc(REG_EAD, 16'h3333);
    seta(16'h000d);
    wr(REG_EAC, 16'h401f);
    wr(REG_EAD, 16'h0000);
    rdc(REG_EAC, 16'h401f);
  endtask
  task automatic t_an();
    wr(REG_BMC, 16'h1340);
    chk({15'h0, tx_halt}, 16'h0001);
    wait_flp();
    chk({14'h0, tx_halt, flp_en}, 16'h0001);
    @(posedge mclk);
    lp_page     <= 16'h0de1;
    lp_page_vld <= 1'b1;
    @(posedge mclk);
    lp_page_vld <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({15'h0, an_complete}, 16'h0001);
    chk({13'h0, speed_sel, full_duplex}, 16'h0003);
    rdc(REG_LPA, 16'h0de1);
    rd(REG_EXP);
    chk(v & 16'h0001, 16'h0001);
    @(posedge mclk);
    link_ok <= 1'b0;
    wait_flp();
    chk({15'h0, flp_en}, 16'h0001);
    @(posedge mclk);
    pd_fault <= 1'b1;
    @(posedge mclk);
    pd_fault <= 1'b0;
    rd(REG_EXP);
    chk(v & 16'h0010, 16'h0010);
    @(posedge mclk);
    pd_100    <= 1'b1;
    pd_detect <= 1'b1;
    @(posedge mclk);
    pd_detect <= 1'b0;
    rdc(REG_LPA, 16'h0081);
    rd(REG_BMS);
    chk(v & 16'h0020, 16'h0020);
    rd(REG_EXP);
    chk(v & 16'h0001, 16'h0000);
    wr(REG_NPT, 16'ha005);
    wr(REG_BMC, 16'h0140);
    wr(REG_BMC, 16'h1140);
    chk({15'h0, tx_halt}, 16'h0001);
  endtask
  // Gigabit partner with one next page; local side single port at first
  task automatic t_gig();
    @(posedge mclk);
    gig_local         <= 1'b1;
    gig_partner       <= 1'b1;
    multiport_partner <= 1'b1;
    wait_flp();
    @(posedge mclk);
    lp_page     <= 16'h8de1;
    lp_page_vld <= 1'b1;
    @(posedge mclk);
    lp_page_vld <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({14'h0, an_complete, flp_en}, 16'h0001);
    lp_page   <= 16'h0de1;
    lp_np_vld <= 1'b1;
    @(posedge mclk);
    lp_np_vld <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({12'h0, speed_sel, full_duplex, gig_master}, 16'h000a);
    multiport_local <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({12'h0, speed_sel, full_duplex, gig_master}, 16'h000b);
  endtask
  task automatic t_x();
    chk({15'h0, crossed_sel}, 16'h0001);
    @(posedge mclk);
    x_detect <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({15'h0, crossed_sel}, 16'h0000);
    @(posedge mclk);
    x_detect <= 1'b1;
    wr(REG_PSC, 16'h5008);
    chk({15'h0, crossed_sel}, 16'h0000);
    wr(REG_PSC, 16'h5028);
    chk({15'h0, crossed_sel}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {mclk, rst_n, lp_page_vld, lp_np_vld, pd_detect, pd_fault} = '0;
    {pd_100, lp_page} = '0;
    {gig_local, gig_partner, multiport_local, multiport_partner} = '0;
    link_ok  = 1'b1;
    x_detect = 1'b1;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    t_reset();
    t_ext();
    t_an();
    t_gig();
    t_x();
    final_report();
  end
  // Runs are about 325 us; stop before the cycle budget is spent
  initial begin
    #900000;
    miscompares++;
    final_report();
  end
endmodule // phyan_regs_bench
